/* core/serial_port_shift_engine.sv */
// serial port engine: shift mode and 10-bit asynchronous mode
module serial_port_shift_engine
  import serial_port_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] mode,
  input wire logic receiveEnable,
  input wire logic multiprocFilter,
  input wire logic baudDoubler,
  input wire logic [7:0] overflowTimerReload,
  input wire logic bufferWrite,
  input wire logic [7:0] bufferWriteData,
  input wire logic controlWrite,
  input wire logic clearTxDone,
  input wire logic clearRxDone,
  input wire logic rxPin,
  output logic txPinOut,
  output logic rxPinOut,
  output logic rxPinOe,
  output logic [7:0] serialBuffer,
  output logic ninthRxBit,
  output logic txDoneFlag,
  output logic rxDoneFlag,
  output logic txBusy,
  output logic rxBusy
);
  logic [2:0] phase;
  logic tick;
  logic [3:0] tickCount;
  logic bitTick;
  logic [8:0] txShift;
  logic [1:0] txStage;
  logic txPending;
  logic txFinal;
  logic txAsyncDone;
  logic [8:0] rxShift;
  logic [7:0] syncRxWord;
  logic [7:0] syncRxByte;
  logic [7:0] asyncRxByte;
  logic rxPrev;
  logic [2:0] samples;
  logic rxMajority;
  logic rxArm;
  logic rxFinal;
  logic shiftClock;
  logic syncTxSet;
  logic syncRxSet;
  logic asyncRxSet;
  logic txStart;
  logic rxStart;
  logic inShift;

  assign inShift = (mode == MODE_SHIFT);
  // phase 0..5 stands for S1..S6 of a machine cycle; six clocks per bit
  assign bitTick = (phase == 3'(PHASES_PER_CYCLE - 1));
  assign txFinal = (txShift[8:1] == 8'h01);
  assign rxMajority = (samples[0] & samples[1]) | (samples[1] & samples[2]) |
                      (samples[0] & samples[2]);
  assign syncTxSet = inShift && txBusy && bitTick && txFinal;
  assign rxFinal = !rxShift[8];
  assign syncRxSet = inShift && rxBusy && bitTick && !rxShift[7];
  assign txStart = bufferWrite;
  assign rxStart = inShift && receiveEnable && !rxDoneFlag && !rxBusy && !rxArm;
  assign syncRxWord = {rxShift[6:0], samples[0]};

  // the first bit in ends highest in the shift register; the buffer wants it in bit 0
  for (genvar gi = 0; gi < 8; gi++) begin : g_rx_order
    assign syncRxByte[gi] = syncRxWord[7 - gi];
    assign asyncRxByte[gi] = rxShift[7 - gi];
  end

  baud_tick_gen ticker (
    .clock(clock),
    .nrst(nrst),
    .mode(mode),
    .baudDoubler(baudDoubler),
    .overflowTimerReload(overflowTimerReload),
    .tick(tick)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase <= 3'h0;
    end else begin
      phase <= bitTick ? 3'h0 : phase + 3'h1;
    end
  end

  // divide-by-16 counter, realigned by a receive start edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tickCount <= 4'h0;
    end else if (!inShift && !rxBusy && rxPrev && !rxPin) begin
      tickCount <= 4'h0;
    end else if (tick) begin
      tickCount <= tickCount + 4'h1;
    end
  end

  // transmit path
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txShift <= 9'h1FF;
      txBusy <= 1'b0;
      txPending <= 1'b0;
      txStage <= 2'h0;
      txAsyncDone <= 1'b0;
    end else begin
      txAsyncDone <= 1'b0;
      if (txStart) begin
        txShift <= {1'b1, bufferWriteData};
        txPending <= 1'b1;
        txBusy <= 1'b0;
        txStage <= 2'h0;
      end else if (inShift) begin
        if (txPending && bitTick) begin
          txPending <= 1'b0;
          txBusy <= 1'b1;
        end else if (txBusy && bitTick) begin
          txShift <= {1'b0, txShift[8:1]};
          if (txFinal) begin
            txBusy <= 1'b0;
          end
        end
      end else if (tick && tickCount == 4'hF) begin
        if (txPending) begin
          txPending <= 1'b0;
          txBusy <= 1'b1;
          txStage <= 2'h1;
        end else if (txBusy) begin
          if (txStage == 2'h1) begin
            txStage <= 2'h2;
          end else if (txFinal) begin
            txShift <= {1'b0, txShift[8:1]};
            txBusy <= 1'b0;
            txStage <= 2'h0;
            txAsyncDone <= 1'b1;
          end else begin
            txShift <= {1'b0, txShift[8:1]};
          end
        end
      end
    end
  end

  // shift clock: low in S3..S5, high in S6, S1, S2
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shiftClock <= 1'b1;
    end else begin
      shiftClock <= !(phase >= 3'h1 && phase <= 3'h3);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txPinOut <= 1'b1;
      rxPinOut <= 1'b1;
      rxPinOe <= 1'b0;
    end else if (inShift) begin
      txPinOut <= (txBusy || rxBusy) ? shiftClock : 1'b1;
      rxPinOut <= txShift[0];
      rxPinOe <= txBusy;
    end else begin
      rxPinOe <= 1'b0;
      rxPinOut <= 1'b1;
      if (!txBusy || txStage == 2'h0) begin
        txPinOut <= 1'b1;
      end else if (txStage == 2'h1) begin
        txPinOut <= 1'b0;
      end else begin
        txPinOut <= txShift[0];
      end
    end
  end

  // receive path
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxShift <= RX_ASYNC_PRELOAD;
      rxBusy <= 1'b0;
      rxArm <= 1'b0;
      rxPrev <= 1'b1;
      samples <= 3'h7;
      serialBuffer <= 8'h00;
      ninthRxBit <= 1'b0;
      asyncRxSet <= 1'b0;
    end else begin
      rxPrev <= rxPin;
      asyncRxSet <= 1'b0;
      if (inShift) begin
        if (rxStart) begin
          rxArm <= 1'b1;
        end else if (rxArm && bitTick) begin
          rxArm <= 1'b0;
          rxBusy <= 1'b1;
          rxShift <= {1'b1, RX_SHIFT_PRELOAD};
        end else if (rxBusy && phase == 3'h4) begin
          samples[0] <= rxPin;
        end else if (rxBusy && bitTick) begin
          rxShift <= {1'b1, rxShift[6:0], samples[0]};
          if (!rxShift[7]) begin
            serialBuffer <= syncRxByte;
            rxBusy <= 1'b0;
          end
        end
      end else if (!rxBusy) begin
        if (rxPrev && !rxPin) begin
          rxBusy <= 1'b1;
          rxShift <= RX_ASYNC_PRELOAD;
        end
      end else if (tick) begin
        if (tickCount == SAMPLE_A) samples[0] <= rxPin;
        if (tickCount == SAMPLE_B) samples[1] <= rxPin;
        if (tickCount == SAMPLE_C) samples[2] <= rxPin;
        if (tickCount == 4'hF) begin
          if (rxShift == RX_ASYNC_PRELOAD && rxMajority) begin
            rxBusy <= 1'b0;
          end else if (rxFinal) begin
            rxBusy <= 1'b0;
            if (!rxDoneFlag && (!multiprocFilter || rxMajority)) begin
              serialBuffer <= asyncRxByte;
              ninthRxBit <= rxMajority;
              asyncRxSet <= 1'b1;
            end
          end else begin
            rxShift <= {rxShift[7:0], rxMajority};
          end
        end
      end
    end
  end

  // done flags: hardware sets, only a control write clears; set wins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txDoneFlag <= 1'b0;
      rxDoneFlag <= 1'b0;
    end else begin
      if (syncTxSet || txAsyncDone) begin
        txDoneFlag <= 1'b1;
      end else if (controlWrite && clearTxDone) begin
        txDoneFlag <= 1'b0;
      end
      if (syncRxSet || asyncRxSet) begin
        rxDoneFlag <= 1'b1;
      end else if (controlWrite && clearRxDone) begin
        rxDoneFlag <= 1'b0;
      end
    end
  end
endmodule : serial_port_shift_engine

/* core/serial_port_pkg.sv */
// constants for the serial port shift engine
// Overview of operation
// - shift mode bit rate is clock over six
// - fixed 9-bit mode: clock/32, doubled clock/16
// - variable modes use timer overflow, /192 or /96
// - shift mode: data on rx line, clock on tx
// - buffer write loads marker, send one cycle later
// - sending routes shift data and clock to pins
// - clock low S3-S5, shift right at S6P2
// - zero fill; final shift sets tx done flag
// - receive allowed: load 11111110, then start receive
// - toggle clock, shift left with S5P2 sample
// - start zero reaches left: load buffer, set flag
// - async frame: start, 8 data LSB first, stop
// - async write: marker, start after rollover
// - start bit, then data, then first shift
// - marker left of MSB: final shift, set flag
// - falling rx edge resets counter, preloads 1FFH
// - majority of samples 7,8,9; false start aborts
// - load only if flag clear and filter passes
package serial_port_pkg;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_VAR8 = 2'h1;
  localparam logic [1:0] MODE_FIX9 = 2'h2;
  localparam logic [1:0] MODE_VAR9 = 2'h3;
  localparam int PHASES_PER_CYCLE = 6;
  localparam int FIX_DIV_SLOW = 32;
  localparam int FIX_DIV_FAST = 16;
  localparam int TIMER_PRESCALE_SLOW = 12;
  localparam int TIMER_PRESCALE_FAST = 6;
  localparam int TIMER_SPAN = 256;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_A = 4'h6;
  localparam logic [3:0] SAMPLE_B = 4'h7;
  localparam logic [3:0] SAMPLE_C = 4'h8;
  localparam logic [8:0] RX_ASYNC_PRELOAD = 9'h1FF;
  localparam logic [7:0] RX_SHIFT_PRELOAD = 8'hFE;
  localparam int TX_BITS = 10;
endpackage : serial_port_pkg

/* core/baud_tick_gen.sv */
// sixteenth-bit tick generator for the asynchronous modes
module baud_tick_gen
  import serial_port_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] mode,
  input wire logic baudDoubler,
  input wire logic [7:0] overflowTimerReload,
  output logic tick
);
  logic [4:0] fixCount;
  logic [3:0] preCount;
  logic [7:0] timerCount;
  logic fixTick;
  logic timerTick;
  logic [4:0] fixLimit;
  logic [3:0] preLimit;

  // fixed mode: 16 ticks per bit over 32 or 16 clocks, so 2 or 1 clocks per tick
  assign fixLimit = baudDoubler ? 5'(FIX_DIV_FAST / OVERSAMPLE - 1)
                                : 5'(FIX_DIV_SLOW / OVERSAMPLE - 1);
  // timer overflow every prescale*(256-reload); 16 overflows per bit: 192 or 96
  assign preLimit = baudDoubler ? 4'(TIMER_PRESCALE_FAST - 1)
                                : 4'(TIMER_PRESCALE_SLOW - 1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fixCount <= 5'h00;
      fixTick <= 1'b0;
    end else begin
      fixTick <= (fixCount >= fixLimit);
      fixCount <= (fixCount >= fixLimit) ? 5'h00 : fixCount + 5'h01;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      preCount <= 4'h0;
      timerCount <= 8'h00;
      timerTick <= 1'b0;
    end else begin
      timerTick <= 1'b0;
      if (preCount >= preLimit) begin
        preCount <= 4'h0;
        if (timerCount == 8'hFF) begin
          timerCount <= overflowTimerReload;
          timerTick <= 1'b1;
        end else begin
          timerCount <= timerCount + 8'h01;
        end
      end else begin
        preCount <= preCount + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick <= 1'b0;
    end else begin
      tick <= (mode == MODE_FIX9) ? fixTick : timerTick;
    end
  end
endmodule : baud_tick_gen

/* dv/serial_port_checker_sva.sv */
// assertion checker for the serial port shift engine
module serial_port_checker
  import serial_port_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] mode,
  input wire logic bufferWrite,
  input wire logic controlWrite,
  input wire logic clearTxDone,
  input wire logic clearRxDone,
  input wire logic txPinOut,
  input wire logic rxPinOut,
  input wire logic rxPinOe,
  input wire logic txDoneFlag,
  input wire logic rxDoneFlag,
  input wire logic txBusy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire shiftMode = (mode == MODE_SHIFT);
  AST_SEND_START: assert property (shiftMode && bufferWrite && !txBusy |-> ##[1:7] $rose(txBusy))
    else $error("send phase late");
  AST_SEND_END: assert property ($rose(txBusy) && shiftMode |-> ##48 ($fell(txBusy) && txDoneFlag))
    else $error("send end or done flag wrong");
  AST_CLK_LOW: assert property (shiftMode && txBusy && $fell(txPinOut) |=> !txPinOut[*2] ##1 txPinOut)
    else $error("shift clock low span wrong");
  AST_CLK_HIGH: assert property (shiftMode && txBusy && $rose(txPinOut) |=> txPinOut[*2])
    else $error("shift clock high span wrong");
  AST_DATA_HOLD: assert property (shiftMode && txBusy && $changed(rxPinOut) |=> ($stable(rxPinOut) || !txBusy)[*4])
    else $error("shift data moved early");
  AST_OE_ROUTE: assert property ($past(txBusy) == txBusy |-> rxPinOe == (txBusy && shiftMode))
    else $error("data pin drive wrong");
  AST_TX_STICKY: assert property (txDoneFlag && !(controlWrite && clearTxDone) |=> txDoneFlag)
    else $error("tx done dropped");
  AST_RX_STICKY: assert property (rxDoneFlag && !(controlWrite && clearRxDone) |=> rxDoneFlag)
    else $error("rx done dropped");
  AST_TX_CLEAR: assert property (controlWrite && clearTxDone && !txBusy && !$fell(txBusy)
    |=> !txDoneFlag)
    else $error("tx done not cleared");
  AST_ASYNC_IDLE: assert property (!shiftMode && !txBusy && !$past(txBusy) |-> txPinOut)
    else $error("line not idle high");
  AST_START_BIT: assert property (!shiftMode && $rose(txBusy) |-> ##[0:1] !txPinOut)
    else $error("no start bit");
  cover property ($rose(txDoneFlag) && shiftMode);
  cover property ($rose(rxDoneFlag) && shiftMode);
  cover property ($rose(rxDoneFlag) && !shiftMode);
endmodule : serial_port_checker
bind serial_port_shift_engine serial_port_checker i_chk (
  .clock(clock),
  .nrst(nrst),
  .mode(mode),
  .bufferWrite(bufferWrite),
  .controlWrite(controlWrite),
  .clearTxDone(clearTxDone),
  .clearRxDone(clearRxDone),
  .txPinOut(txPinOut),
  .rxPinOut(rxPinOut),
  .rxPinOe(rxPinOe),
  .txDoneFlag(txDoneFlag),
  .rxDoneFlag(rxDoneFlag),
  .txBusy(txBusy)
);

/* dv/far_station.sv */
// far-side model: async station and external shift register
module far_station (
  input wire logic clock,
  input wire logic txLine,
  input wire logic dataLine,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line = 1'b1;
  task automatic send(input logic [7:0] v, input logic stopBit, input int bt);
    logic [9:0] fr;
    fr = {stopBit, v, 1'b0};
    @(negedge clock) line = 1'b1;
    repeat (bt) @(negedge clock);
    for (int i = 0; i < 10; i++) begin
      line = fr[i];
      repeat (bt) @(negedge clock);
    end
    line = 1'b1;
  endtask : send
  task automatic pulse(input int n);
    line = 1'b0;
    repeat (n) @(negedge clock);
    line = 1'b1;
  endtask : pulse
  task automatic recv(input int bt, output logic [9:0] v);
    @(negedge txLine);
    repeat (bt / 2) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      v[i] = txLine;
      repeat (bt) @(posedge clock);
    end
  endtask : recv
  task automatic shift_in(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(negedge txLine) v[i] = dataLine;
    end
  endtask : shift_in
  task automatic shift_out(input logic [7:0] v);
    line = v[0];
    for (int i = 1; i < 8; i++) begin
      @(posedge txLine) line = v[i];
    end
    repeat (6) @(posedge clock);
    line = ~v[7];
  endtask : shift_out
endmodule : far_station

/* dv/serial_port_shift_engine_test.sv */
// self-checking bench for the serial port shift engine
module serial_port_shift_engine_test;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_port_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, receiveEnable = 1'b0, multiprocFilter = 1'b0;
  logic baudDoubler = 1'b1, bufferWrite = 1'b0, controlWrite = 1'b0;
  logic clearTxDone = 1'b1, clearRxDone = 1'b1;
  logic [1:0] mode = MODE_SHIFT;
  logic [7:0] overflowTimerReload = 8'hFF, bufferWriteData = 8'h00, serialBuffer, d, got;
  logic txPinOut, rxPinOut, rxPinOe, ninthRxBit, txDoneFlag, rxDoneFlag, txBusy, rxBusy;
  logic [9:0] f;
  logic [7:0] expq[$];
  wire farLine;
  wire rxPin = rxPinOe ? rxPinOut : farLine;
  int n_errors = 0, tests_run = 0, bt;
  serial_port_shift_engine i_dut (
    .clock(clock),
    .nrst(nrst),
    .mode(mode),
    .receiveEnable(receiveEnable),
    .multiprocFilter(multiprocFilter),
    .baudDoubler(baudDoubler),
    .overflowTimerReload(overflowTimerReload),
    .bufferWrite(bufferWrite),
    .bufferWriteData(bufferWriteData),
    .controlWrite(controlWrite),
    .clearTxDone(clearTxDone),
    .clearRxDone(clearRxDone),
    .rxPin(rxPin),
    .txPinOut(txPinOut),
    .rxPinOut(rxPinOut),
    .rxPinOe(rxPinOe),
    .serialBuffer(serialBuffer),
    .ninthRxBit(ninthRxBit),
    .txDoneFlag(txDoneFlag),
    .rxDoneFlag(rxDoneFlag),
    .txBusy(txBusy),
    .rxBusy(rxBusy)
  );
  far_station i_far (.clock(clock), .txLine(txPinOut), .dataLine(rxPin), .line(farLine));
  initial forever #10 clock = ~clock;
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t data %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t bit %b expected %b", $time, g, e);
    end
  endtask : chk1
  task automatic wr(input logic [7:0] v);
    @(negedge clock);
    bufferWrite = 1'b1;
    bufferWriteData = v;
    expq.push_back(v);
    @(negedge clock);
    bufferWrite = 1'b0;
  endtask : wr
  task automatic clr;
    @(negedge clock);
    controlWrite = 1'b1;
    @(negedge clock);
    controlWrite = 1'b0;
  endtask : clr
  task automatic wait_for(input bit rx);
    int w;
    for (w = 0; w < 5000 && (rx ? rxDoneFlag : txDoneFlag) !== 1'b1; w++) @(negedge clock);
    if (w == 5000) chk1(1'b0, 1'b1);
  endtask : wait_for
  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    void'($urandom(94));
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    chk1(txPinOut, 1'b1);
    chk1(rxPinOe, 1'b0);
    chk8(serialBuffer, 8'h00);
    d = 8'($urandom);
    fork
      i_far.shift_in(got);
      wr(d);
    join
    wait_for(0);
    chk8(got, expq.pop_front());
    chk1(txBusy, 1'b0);
    $display("test shift transmit done");
    clr;
    d = 8'($urandom);
    fork
      i_far.shift_out(d);
      begin
        @(negedge clock) receiveEnable = 1'b1;
        wait_for(1);
      end
    join
    receiveEnable = 1'b0;
    chk8(serialBuffer, d);
    clearRxDone = 1'b0;
    clr;
    repeat (30) @(negedge clock);
    chk1(rxDoneFlag, 1'b1);
    clearRxDone = 1'b1;
    clr;
    chk1(rxDoneFlag, 1'b0);
    $display("test shift receive done");
    for (int k = 0; k < 5; k++) begin
      clr;
      mode = (k < 2) ? MODE_FIX9 : MODE_VAR8;
      baudDoubler = (k != 0 && k != 3);
      overflowTimerReload = (k == 4) ? 8'hFE : 8'hFF;
      if (k < 2) bt = baudDoubler ? FIX_DIV_FAST : FIX_DIV_SLOW;
      else bt = (baudDoubler ? 96 : 192) * (256 - int'(overflowTimerReload));
      fork
        i_far.recv(bt, f);
        wr(8'($urandom));
      join
      wait_for(0);
      chk8(f[8:1], expq.pop_front());
      chk1(f[0], 1'b0);
      chk1(f[9], 1'b1);
    end
    $display("test async transmit done");
    clr;
    receiveEnable = 1'b1;
    d = 8'($urandom);
    i_far.send(d, 1'b1, bt);
    wait_for(1);
    chk8(serialBuffer, d);
    chk1(ninthRxBit, 1'b1);
    i_far.send(~d, 1'b1, bt);
    chk8(serialBuffer, d);
    clr;
    multiprocFilter = 1'b1;
    i_far.send(~d, 1'b0, bt);
    repeat (bt) @(negedge clock);
    chk1(rxDoneFlag, 1'b0);
    multiprocFilter = 1'b0;
    i_far.pulse(bt / 4);
    repeat (bt * 11) @(negedge clock);
    chk1(rxDoneFlag, 1'b0);
    i_far.send(~d, 1'b1, bt);
    wait_for(1);
    chk8(serialBuffer, ~d);
    $display("test async receive done");
    test_done();
  end
endmodule : serial_port_shift_engine_test
